// >>> hdl/bpmrc_config_bank.sv
`timescale 1ns/100ps
`include "bpmrc_regs.svh"
module bpmrc_config_bank #(
  parameter int RETRY_TIMEOUT = `BPMRC_RETRY_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic       cfg_write,
  input  wire logic       cfg_read,
  input  wire logic       cfg_function,
  input  wire logic [7:0] cfg_offset,
  input  wire logic [7:0] cfg_wdata,
  output logic      [7:0] cfg_rdata,
  input  wire logic       host_retry_issued,
  input  wire logic       host_master_returned,
  input  wire logic [1:0] card_retry_issued,
  input  wire logic [1:0] card_master_returned,
  input  wire logic [1:0] card_irq_pin,
  input  wire logic [1:0] card_speaker_in,
  input  wire logic [1:0] card_audio_signal,
  input  wire logic       ring_indicate_in,
  output logic      [2:0] pin0_route_select,
  output logic      [2:0] pin1_route_select,
  output logic      [2:0] pin2_route_select,
  output logic            host_retry_counter_en,
  output logic            card_retry_counter_en,
  output logic            ring_indicate_output,
  output logic            ring_output_enable,
  output logic      [1:0] socket_video_isolate,
  output logic      [1:0] socket_video_enable,
  output logic            card_audio_pwm,
  output logic            card_audio_pwm_valid,
  output logic            combined_speaker_out,
  output logic            combined_speaker_oe
);
  // ****************************************
  // Storage.
  // ****************************************
  logic [7:0] retry_timeout_status;
  logic [7:0] card_compat_control [2];
  logic [1:0] irq_sync1;
  logic [1:0] irq_sync2;
  logic [1:0] irq_prev;
  logic [1:0] spk_sync1;
  logic [1:0] spk_sync2;
  logic [1:0] aud_sync1;
  logic [1:0] aud_sync2;
  logic       ring_sync1;
  logic       ring_sync2;
  logic       host_expired;
  logic [1:0] card_expired;
  logic [1:0] irq_event;

  // A write strobe aimed at one byte offset.
  function automatic logic hit(input logic [7:0] off, input logic [7:0] want);
    return cfg_write && (off == want);
  endfunction

  // True while either function has the speaker path switched on.
  function automatic logic speaker_on(input logic [7:0] f0, input logic [7:0] f1);
    return f0[`BPMRC_SPEAKER_BIT] | f1[`BPMRC_SPEAKER_BIT];
  endfunction

  // Reserved retry bits are masked at readback as well as in storage, a cheap second guard.
  function automatic logic [7:0] retry_view(input logic [7:0] r);
    return r & 8'hea;
  endfunction

  // Card bits 4 and 3 are read-only zero whatever the storage holds.
  function automatic logic [7:0] card_view(input logic [7:0] r);
    return r & 8'he7;
  endfunction

  // ****************************************
  // Input synchronisers.
  // ****************************************
  // Card-side pins arrive asynchronously, so each passes two flops first.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq_sync1  <= 2'h0;
      irq_sync2  <= 2'h0;
      irq_prev   <= 2'h0;
      spk_sync1  <= 2'h0;
      spk_sync2  <= 2'h0;
      aud_sync1  <= 2'h0;
      aud_sync2  <= 2'h0;
      ring_sync1 <= 1'b0;
      ring_sync2 <= 1'b0;
    end else begin
      irq_sync1  <= card_irq_pin;
      irq_sync2  <= irq_sync1;
      irq_prev   <= irq_sync2;
      spk_sync1  <= card_speaker_in;
      spk_sync2  <= spk_sync1;
      aud_sync1  <= card_audio_signal;
      aud_sync2  <= aud_sync1;
      ring_sync1 <= ring_indicate_in;
      ring_sync2 <= ring_sync1;
    end
  end

  // A rising edge of the synchronised interrupt pin, one pulse per socket.
  assign irq_event = irq_sync2 & ~irq_prev;

  // ****************************************
  // Retry timers.
  // ****************************************
  // A second retry while a count runs does not restart it; the first retry sets the deadline.
  // Clearing an enable aborts a running count, so no stale expiry appears later.
  bpmrc_retry_timer #(.TIMEOUT(RETRY_TIMEOUT)) u_host_timer (
    .clock           (clock),
    .reset_n         (reset_n),
    .enable          (retry_timeout_status[`BPMRC_HOST_EN_BIT]),
    .retry_issued    (host_retry_issued),
    .master_returned (host_master_returned),
    .expired         (host_expired)
  );

  // Socket A is index 0 and socket B index 1; both share the card enable bit.
  genvar s;
  generate
    for (s = 0; s < 2; s++) begin : g_card_timer
      bpmrc_retry_timer #(.TIMEOUT(RETRY_TIMEOUT)) u_card_timer (
        .clock           (clock),
        .reset_n         (reset_n),
        .enable          (retry_timeout_status[`BPMRC_CARD_EN_BIT]),
        .retry_issued    (card_retry_issued[s]),
        .master_returned (card_master_returned[s]),
        .expired         (card_expired[s])
      );
    end
  endgenerate

  // ****************************************
  // Pin routing selects.
  // ****************************************
  // Only the three select fields are stored, so reserved bits cannot hold data.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      {pin2_route_select, pin1_route_select, pin0_route_select} <= 9'(`BPMRC_ROUTE_RESET);
    end else begin
      if (hit(cfg_offset, `BPMRC_ROUTE_OFFSET_0)) begin
        pin0_route_select <= cfg_wdata[2:0];
        pin1_route_select <= cfg_wdata[6:4];
      end
      if (hit(cfg_offset, `BPMRC_ROUTE_OFFSET_1)) begin
        pin2_route_select <= cfg_wdata[2:0];
      end
    end
  end

  // ****************************************
  // Retry status register.
  // ****************************************
  // Expiry wins over a same-cycle write of one, so no event is lost.
  // Reserved bits are forced to zero every cycle, so no write can leave data there.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      retry_timeout_status <= `BPMRC_RETRY_RESET;
    end else begin
      if (hit(cfg_offset, `BPMRC_RETRY_OFFSET)) begin
        retry_timeout_status[`BPMRC_HOST_EN_BIT] <= cfg_wdata[`BPMRC_HOST_EN_BIT];
        retry_timeout_status[`BPMRC_CARD_EN_BIT] <= cfg_wdata[`BPMRC_CARD_EN_BIT];
        if (cfg_wdata[`BPMRC_EXP_B_BIT]) begin
          retry_timeout_status[`BPMRC_EXP_B_BIT] <= 1'b0;
        end
        if (cfg_wdata[`BPMRC_EXP_A_BIT]) begin
          retry_timeout_status[`BPMRC_EXP_A_BIT] <= 1'b0;
        end
        if (cfg_wdata[`BPMRC_EXP_HOST_BIT]) begin
          retry_timeout_status[`BPMRC_EXP_HOST_BIT] <= 1'b0;
        end
      end
      if (card_expired[1]) begin
        retry_timeout_status[`BPMRC_EXP_B_BIT] <= 1'b1;
      end
      if (card_expired[0]) begin
        retry_timeout_status[`BPMRC_EXP_A_BIT] <= 1'b1;
      end
      if (host_expired) begin
        retry_timeout_status[`BPMRC_EXP_HOST_BIT] <= 1'b1;
      end
      retry_timeout_status[4] <= 1'b0;
      retry_timeout_status[2] <= 1'b0;
      retry_timeout_status[0] <= 1'b0;
    end
  end

  // ****************************************
  // Card control, one copy per function.
  // ****************************************
  // Ring enable is global: a write from either function updates both copies.
  // Each socket sees only its own interrupt pin, so the flag is never shared.
  generate
    for (s = 0; s < 2; s++) begin : g_card_ctrl
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          card_compat_control[s] <= `BPMRC_CARD_RESET;
        end else begin
          if (hit(cfg_offset, `BPMRC_CARD_OFFSET)) begin
            card_compat_control[s][`BPMRC_RING_BIT] <= cfg_wdata[`BPMRC_RING_BIT];
          end
          if (hit(cfg_offset, `BPMRC_CARD_OFFSET) && (cfg_function == 1'(s))) begin
            card_compat_control[s][`BPMRC_ISOLATE_BIT] <= cfg_wdata[`BPMRC_ISOLATE_BIT];
            card_compat_control[s][`BPMRC_SPARE_BIT]   <= cfg_wdata[`BPMRC_SPARE_BIT];
            card_compat_control[s][`BPMRC_AUDIO_BIT]   <= cfg_wdata[`BPMRC_AUDIO_BIT];
            card_compat_control[s][`BPMRC_SPEAKER_BIT] <= cfg_wdata[`BPMRC_SPEAKER_BIT];
            if (cfg_wdata[`BPMRC_IRQ_BIT]) begin
              card_compat_control[s][`BPMRC_IRQ_BIT] <= 1'b0;
            end
          end
          if (irq_event[s]) begin
            card_compat_control[s][`BPMRC_IRQ_BIT] <= 1'b1;
          end
          card_compat_control[s][4:3] <= 2'h0;
        end
      end
    end
  endgenerate

  // ****************************************
  // Read data.
  // ****************************************
  // Read data is registered, valid the cycle after the read strobe.
  // Unmapped offsets read zero, and writes to them reach no register.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cfg_rdata <= 8'h00;
    end else if (cfg_read) begin
      case (cfg_offset)
        `BPMRC_ROUTE_OFFSET_0: cfg_rdata <= {1'b0, pin1_route_select, 1'b0, pin0_route_select};
        `BPMRC_ROUTE_OFFSET_1: cfg_rdata <= {5'h00, pin2_route_select};
        `BPMRC_RETRY_OFFSET:   cfg_rdata <= retry_view(retry_timeout_status);
        `BPMRC_CARD_OFFSET:    cfg_rdata <= card_view(card_compat_control[cfg_function]);
        default:               cfg_rdata <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // Outputs toward pins and other blocks.
  // ****************************************
  // The isolate bit drives both socket_video_isolate and socket_video_enable.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      host_retry_counter_en <= 1'b1;
      card_retry_counter_en <= 1'b1;
      ring_output_enable    <= 1'b0;
      ring_indicate_output  <= 1'b0;
      socket_video_isolate  <= 2'h0;
      socket_video_enable   <= 2'h0;
      card_audio_pwm        <= 1'b0;
      card_audio_pwm_valid  <= 1'b0;
      combined_speaker_out  <= 1'b0;
      combined_speaker_oe   <= 1'b0;
    end else begin
      host_retry_counter_en <= retry_timeout_status[`BPMRC_HOST_EN_BIT];
      card_retry_counter_en <= retry_timeout_status[`BPMRC_CARD_EN_BIT];
      ring_output_enable    <= card_compat_control[0][`BPMRC_RING_BIT];
      ring_indicate_output  <= card_compat_control[0][`BPMRC_RING_BIT] & ring_sync2;
      socket_video_isolate  <= {card_compat_control[1][`BPMRC_ISOLATE_BIT],
                                card_compat_control[0][`BPMRC_ISOLATE_BIT]};
      socket_video_enable   <= {card_compat_control[1][`BPMRC_ISOLATE_BIT],
                                card_compat_control[0][`BPMRC_ISOLATE_BIT]};
      // Audio code 0 routes; socket 0 takes priority when both route.
      if (!card_compat_control[0][`BPMRC_AUDIO_BIT]) begin
        card_audio_pwm       <= aud_sync2[0];
        card_audio_pwm_valid <= 1'b1;
      end else if (!card_compat_control[1][`BPMRC_AUDIO_BIT]) begin
        card_audio_pwm       <= aud_sync2[1];
        card_audio_pwm_valid <= 1'b1;
      end else begin
        card_audio_pwm       <= 1'b0;
        card_audio_pwm_valid <= 1'b0;
      end
      // The speaker pin is only driven while some function has enabled it.
      combined_speaker_oe  <= speaker_on(card_compat_control[0], card_compat_control[1]);
      combined_speaker_out <= (spk_sync2[0] ^ spk_sync2[1])
                            & speaker_on(card_compat_control[0], card_compat_control[1]);
    end
  end
endmodule // bpmrc_config_bank

// >>> hdl/bpmrc_pkg.sv
package bpmrc_pkg;
  typedef enum logic [2:0] {
    BPMRC_WAIT_IDLE   = 3'b001,
    BPMRC_WAIT_COUNT  = 3'b010,
    BPMRC_WAIT_EXPIRE = 3'b100
  } bpmrc_wait_t;
endpackage

// >>> hdl/bpmrc_regs.svh
`ifndef BPMRC_REGS_SVH
`define BPMRC_REGS_SVH
// Configuration offsets, one byte each.
`define BPMRC_ROUTE_OFFSET_0 8'h8c
`define BPMRC_ROUTE_OFFSET_1 8'h8d
`define BPMRC_RETRY_OFFSET   8'h90
`define BPMRC_CARD_OFFSET    8'h91
// Reset values.
`define BPMRC_RETRY_RESET    8'hc0
`define BPMRC_CARD_RESET     8'h00
`define BPMRC_ROUTE_RESET    12'h000
// Retry status field positions.
`define BPMRC_HOST_EN_BIT    7
`define BPMRC_CARD_EN_BIT    6
`define BPMRC_EXP_B_BIT      5
`define BPMRC_EXP_A_BIT      3
`define BPMRC_EXP_HOST_BIT   1
// Card control field positions.
`define BPMRC_RING_BIT       7
`define BPMRC_ISOLATE_BIT    6
`define BPMRC_SPARE_BIT      5
`define BPMRC_AUDIO_BIT      2
`define BPMRC_SPEAKER_BIT    1
`define BPMRC_IRQ_BIT        0
// Retry time-out, in clock cycles.
`define BPMRC_RETRY_CYCLES   32768
`endif

// >>> hdl/bpmrc_retry_timer.sv
`timescale 1ns/100ps
`include "bpmrc_regs.svh"
// ****************************************
// Retry time-out watcher for one target.
// ****************************************
module bpmrc_retry_timer #(
  parameter int TIMEOUT = `BPMRC_RETRY_CYCLES
) (
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic enable,
  input  wire logic retry_issued,
  input  wire logic master_returned,
  output logic      expired
);
  bpmrc_pkg::bpmrc_wait_t state;
  logic [31:0]            count;

  // Counting starts at a retry and stops when the master completes or the counter is disabled.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state   <= bpmrc_pkg::BPMRC_WAIT_IDLE;
      count   <= 32'h0000_0000;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      case (state)
        bpmrc_pkg::BPMRC_WAIT_IDLE: begin
          count <= 32'h0000_0000;
          if (retry_issued && enable) begin
            state <= bpmrc_pkg::BPMRC_WAIT_COUNT;
          end
        end
        bpmrc_pkg::BPMRC_WAIT_COUNT: begin
          if (master_returned || !enable) begin
            state <= bpmrc_pkg::BPMRC_WAIT_IDLE;
          end else if (count == 32'(TIMEOUT - 1)) begin
            state <= bpmrc_pkg::BPMRC_WAIT_EXPIRE;
          end else begin
            count <= count + 32'h0000_0001;
          end
        end
        bpmrc_pkg::BPMRC_WAIT_EXPIRE: begin
          expired <= 1'b1;
          state   <= bpmrc_pkg::BPMRC_WAIT_IDLE;
        end
        default: state <= bpmrc_pkg::BPMRC_WAIT_IDLE;
      endcase
    end
  end
endmodule // bpmrc_retry_timer

// >>> test/bpmrc_config_bank_sva.sv
`timescale 1ns/100ps
// ****************************************
// Port checker for the configuration bank.
// ****************************************
module bpmrc_config_bank_sva (
  input wire logic       clock,
  input wire logic       reset_n,
  input wire logic       cfg_write,
  input wire logic       cfg_read,
  input wire logic       cfg_function,
  input wire logic [7:0] cfg_offset,
  input wire logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata,
  input wire logic [2:0] pin0_route_select,
  input wire logic [2:0] pin1_route_select,
  input wire logic [2:0] pin2_route_select,
  input wire logic       host_retry_counter_en,
  input wire logic       card_retry_counter_en,
  input wire logic       ring_output_enable,
  input wire logic [1:0] socket_video_isolate,
  input wire logic [1:0] socket_video_enable
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Write steps, one per register byte for function 0, plus a function 1 card write.
  sequence wr_route0; cfg_write && !cfg_function && cfg_offset == 8'h8c; endsequence
  sequence wr_route1; cfg_write && !cfg_function && cfg_offset == 8'h8d; endsequence
  sequence wr_retry;  cfg_write && !cfg_function && cfg_offset == 8'h90; endsequence
  sequence wr_card0;  cfg_write && !cfg_function && cfg_offset == 8'h91; endsequence
  sequence wr_card1;  cfg_write && cfg_function && cfg_offset == 8'h91; endsequence
  chk_pin0_sel_write: assert property (wr_route0 |=>
    pin0_route_select == $past(cfg_wdata[2:0]))
    else $error("pin 0 select missed a write");
  chk_pin1_sel_write: assert property (wr_route0 |=>
    pin1_route_select == $past(cfg_wdata[6:4]))
    else $error("pin 1 select missed a write");
  chk_pin2_sel_write: assert property (wr_route1 |=>
    pin2_route_select == $past(cfg_wdata[2:0]))
    else $error("pin 2 select missed a write");
  chk_route_rsvd_zero: assert property (cfg_read && cfg_offset == 8'h8c |=>
    (cfg_rdata & 8'h88) == 8'h00)
    else $error("routing reserved bits read nonzero");
  chk_retry_rsvd_zero: assert property (cfg_read && cfg_offset == 8'h90 |=>
    (cfg_rdata & 8'h15) == 8'h00)
    else $error("retry reserved bits read nonzero");
  chk_card_rsvd_zero: assert property (cfg_read && cfg_offset == 8'h91 |=>
    (cfg_rdata & 8'h18) == 8'h00)
    else $error("card bits 4 and 3 read nonzero");
  chk_host_en_follow: assert property (wr_retry |=> ##1
    host_retry_counter_en == $past(cfg_wdata[7], 2))
    else $error("host counter enable did not follow bit 7");
  chk_card_en_follow: assert property (wr_retry |=> ##1
    card_retry_counter_en == $past(cfg_wdata[6], 2))
    else $error("card counter enable did not follow bit 6");
  chk_ring_shared: assert property (cfg_write && cfg_offset == 8'h91 |=> ##1
    ring_output_enable == $past(cfg_wdata[7], 2))
    else $error("ring enable missed a write");
  chk_video_alias: assert property (socket_video_isolate == socket_video_enable)
    else $error("video isolate and enable differ");
  chk_video_iso_f0: assert property (wr_card0 |=> ##1
    socket_video_isolate[0] == $past(cfg_wdata[6], 2))
    else $error("socket 0 isolate missed a function 0 write");
  chk_video_iso_f1: assert property (wr_card1 |=> ##1
    socket_video_isolate[1] == $past(cfg_wdata[6], 2))
    else $error("socket 1 isolate missed a function 1 write");
endmodule // bpmrc_config_bank_sva

bind bpmrc_config_bank bpmrc_config_bank_sva u_sva (.clock(clock), .reset_n(reset_n),
  .cfg_write(cfg_write), .cfg_read(cfg_read), .cfg_function(cfg_function),
  .cfg_offset(cfg_offset), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
  .pin0_route_select(pin0_route_select), .pin1_route_select(pin1_route_select),
  .pin2_route_select(pin2_route_select), .host_retry_counter_en(host_retry_counter_en),
  .card_retry_counter_en(card_retry_counter_en), .ring_output_enable(ring_output_enable),
  .socket_video_isolate(socket_video_isolate), .socket_video_enable(socket_video_enable));

// >>> test/bpmrc_host_model.sv
`timescale 1ns/100ps
// ****************************************
// Host model issuing configuration byte cycles.
// ****************************************
module bpmrc_host_model (
  input  wire logic       clock,
  output logic            cfg_write,
  output logic            cfg_read,
  output logic            cfg_function,
  output logic      [7:0] cfg_offset,
  output logic      [7:0] cfg_wdata,
  input  wire logic [7:0] cfg_rdata
);
  // Quiet bus at time zero.
  initial begin
    {cfg_write, cfg_read, cfg_function, cfg_offset, cfg_wdata} = 19'h0;
  end
  // One write cycle; released lines are inverted so nobody trusts stale values.
  task automatic write_byte(input logic f, input logic [7:0] off, input logic [7:0] d);
    @(posedge clock);
    cfg_write    <= 1'b1;
    cfg_function <= f;
    cfg_offset   <= off;
    cfg_wdata    <= d;
    @(posedge clock);
    cfg_write    <= 1'b0;
    cfg_offset   <= ~off;
    cfg_wdata    <= ~d;
  endtask
  // One read cycle; data is taken once the answering edge has landed.
  task automatic read_byte(input logic f, input logic [7:0] off, output logic [7:0] d);
    @(posedge clock);
    cfg_read     <= 1'b1;
    cfg_function <= f;
    cfg_offset   <= off;
    @(posedge clock);
    cfg_read     <= 1'b0;
    cfg_offset   <= ~off;
    #1 d = cfg_rdata;
  endtask
endmodule // bpmrc_host_model

// >>> test/bridge_pin_mux_retry_card_ctrl_test.sv
`timescale 1ns/100ps
module bridge_pin_mux_retry_card_ctrl_test;
  localparam int TMO = 16;
  logic       clock = 1'b0;
  logic       reset_n = 1'b0;
  logic [2:0] kick = 3'h0;
  logic [2:0] back = 3'h0;
  logic [1:0] irq = 2'h0;
  logic [1:0] spk = 2'h0;
  logic [1:0] aud = 2'h0;
  logic       ring = 1'b0;
  logic       wr, rd, fn, pwm, pwm_ok, sp_out, sp_oe, ring_out, ring_en, h_en, c_en;
  logic [7:0] off, wdat, rdat;
  logic [2:0] sel0, sel1, sel2;
  logic [1:0] iso, ven;
  integer     seed, miscompares = 0, cmp_count = 0;
  // Clock at 125 MHz.
  always #4 clock = ~clock;
  bpmrc_host_model host (.clock(clock), .cfg_write(wr), .cfg_read(rd), .cfg_function(fn),
    .cfg_offset(off), .cfg_wdata(wdat), .cfg_rdata(rdat));
  bpmrc_config_bank #(.RETRY_TIMEOUT(TMO)) uut (.clock(clock), .reset_n(reset_n),
    .cfg_write(wr), .cfg_read(rd), .cfg_function(fn), .cfg_offset(off), .cfg_wdata(wdat),
    .cfg_rdata(rdat), .host_retry_issued(kick[2]), .host_master_returned(back[2]),
    .card_retry_issued(kick[1:0]), .card_master_returned(back[1:0]), .card_irq_pin(irq),
    .card_speaker_in(spk), .card_audio_signal(aud), .ring_indicate_in(ring),
    .pin0_route_select(sel0), .pin1_route_select(sel1), .pin2_route_select(sel2),
    .host_retry_counter_en(h_en), .card_retry_counter_en(c_en),
    .ring_indicate_output(ring_out), .ring_output_enable(ring_en),
    .socket_video_isolate(iso), .socket_video_enable(ven), .card_audio_pwm(pwm),
    .card_audio_pwm_valid(pwm_ok), .combined_speaker_out(sp_out), .combined_speaker_oe(sp_oe));
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd_check(input logic f, input logic [7:0] a, input logic [7:0] m,
                          input logic [7:0] exp);
    logic [7:0] d;
    host.read_byte(f, a, d);
    check8(d & m, exp);
  endtask
  // Event pulses; the retry and return lanes are host, socket B, socket A.
  task automatic pulse(input logic [2:0] k, input logic [2:0] b);
    @(posedge clock);
    kick <= k;
    back <= b;
    @(posedge clock);
    kick <= 3'h0;
    back <= 3'h0;
  endtask
  // Routing readback keeps only the select fields.
  function automatic logic [7:0] route_exp(input logic [7:0] d);
    return d & 8'h77;
  endfunction
  // Watchdog: the sequence needs well under 2000 cycles.
  initial begin
    #40000;
    miscompares++;
    final_report();
  end
  // ****************************************
  // Main sequence.
  // ****************************************
  initial begin
    logic [7:0] d;
    seed = 41;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    rd_check(1'b0, 8'h90, 8'hff, 8'hc0);
    rd_check(1'b0, 8'h91, 8'hff, 8'h00);
    rd_check(1'b0, 8'h95, 8'hff, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      host.write_byte(1'b0, 8'h8c, {d[7], i[2:0], d[3], i[2:0]});
      rd_check(1'b0, 8'h8c, 8'hff, route_exp({d[7], i[2:0], d[3], i[2:0]}));
      host.write_byte(1'b0, 8'h8d, {d[4:0], i[2:0]});
      rd_check(1'b0, 8'h8d, 8'hff, {5'h00, i[2:0]});
      check8({sel2[1:0], sel1, sel0}, {i[1:0], i[2:0], i[2:0]});
    end
    $display("routing test done");
    pulse(3'b111, 3'b000);
    repeat (TMO + 8) @(posedge clock);
    rd_check(1'b0, 8'h90, 8'hff, 8'hea);
    host.write_byte(1'b0, 8'h90, 8'hc0);
    rd_check(1'b0, 8'h90, 8'hff, 8'hea);
    host.write_byte(1'b0, 8'h90, 8'hc2);
    rd_check(1'b0, 8'h90, 8'hff, 8'he8);
    host.write_byte(1'b0, 8'h90, 8'hff);
    rd_check(1'b0, 8'h90, 8'hff, 8'hc0);
    pulse(3'b111, 3'b000);
    pulse(3'b000, 3'b111);
    repeat (TMO + 8) @(posedge clock);
    rd_check(1'b0, 8'h90, 8'hff, 8'hc0);
    host.write_byte(1'b0, 8'h90, 8'h00);
    repeat (2) @(posedge clock);
    check8({6'h00, h_en, c_en}, 8'h00);
    pulse(3'b111, 3'b000);
    repeat (TMO + 8) @(posedge clock);
    rd_check(1'b0, 8'h90, 8'hff, 8'h00);
    $display("retry test done");
    host.write_byte(1'b0, 8'h91, 8'hff);
    ring <= 1'b1;
    rd_check(1'b0, 8'h91, 8'hff, 8'he6);
    rd_check(1'b1, 8'h91, 8'hc1, 8'h80);
    check8({4'h0, ven, iso}, 8'h05);
    for (int i = 0; i < 4; i++) begin
      spk <= 2'($random(seed));
      repeat (4) @(posedge clock);
      check8({5'h00, ring_out, sp_oe, sp_out}, {5'h00, 1'b1, 1'b1, ^spk});
    end
    aud <= 2'b01;
    host.write_byte(1'b0, 8'h91, 8'h00);
    repeat (4) @(posedge clock);
    check8({4'h0, ring_out, sp_oe, pwm_ok, pwm}, 8'h03);
    host.write_byte(1'b0, 8'h91, 8'h04);
    repeat (4) @(posedge clock);
    check8({6'h00, pwm_ok, pwm}, 8'h02);
    irq <= 2'b01;
    repeat (5) @(posedge clock);
    rd_check(1'b0, 8'h91, 8'hff, 8'h05);
    rd_check(1'b1, 8'h91, 8'h01, 8'h00);
    host.write_byte(1'b0, 8'h91, 8'h05);
    rd_check(1'b0, 8'h91, 8'hff, 8'h04);
    $display("card control test done");
    final_report();
  end
endmodule // bridge_pin_mux_retry_card_ctrl_test
